//--- hdl/mba_bus_if.sv
// interface: shared bus request lines and open-drain core priority line
interface mba_bus_if;
  import mba_pkg::*;
  // per-device request drives, active high, one slot per line
  logic [MBA_MAX_PROC-1:0] dev_req_drive;
  logic [MBA_MAX_PROC-1:0] dev_req_oe_n;
  logic [MBA_MAX_PROC-1:0] peer_req_drive;
  logic [MBA_MAX_PROC-1:0] peer_req_oe_n;
  logic core_priority_line_oe_n_dev;
  logic core_priority_line_oe_n_peer;
  logic [MBA_MAX_PROC-1:0] bus_request_lines_n;
  logic core_priority_line_n;
  logic rotating_priority_select;
  // resolved wire levels: request lines pulled high when undriven
  genvar g;
  generate
    for (g = 0; g < MBA_MAX_PROC; g++)
    begin : g_line
      assign bus_request_lines_n[g] = ~((~dev_req_oe_n[g] & dev_req_drive[g]) |
                                        (~peer_req_oe_n[g] & peer_req_drive[g]));
    end
  endgenerate
  assign core_priority_line_n = core_priority_line_oe_n_dev & core_priority_line_oe_n_peer;
  modport device (
    output dev_req_drive,
    output dev_req_oe_n,
    output core_priority_line_oe_n_dev,
    input bus_request_lines_n,
    input core_priority_line_n,
    input rotating_priority_select
  );
  modport peer (
    output peer_req_drive,
    output peer_req_oe_n,
    output core_priority_line_oe_n_peer,
    output rotating_priority_select,
    input bus_request_lines_n,
    input core_priority_line_n
  );
endinterface

//--- hdl/mba_device.sv
// device end: distributed bus request arbiter of one processor
module mba_device
  import mba_pkg::*;
#(
  parameter int NUM_PROC = MBA_MAX_PROC
)
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic CLK_EN_I,
  input wire logic [MBA_ID_W-1:0] PROCESSOR_IDENTIFIER_I,
  input wire logic BUS_WANT_I,
  input wire logic CORE_WANT_I,
  input wire logic DMA_BACKGROUND_I,
  output logic BUS_GRANT_O,
  output logic DMA_YIELD_O,
  output logic SINGLE_PROC_O,
  mba_bus_if.device BUS
);
  ////////////////////////////////////////////////////////////////////////////
  // identifier capture at reset release
  logic [MBA_ID_W-1:0] id_reg, id_next;
  logic id_valid_reg, id_valid_next;
  logic single_reg, single_next;
  logic [NUM_PROC-1:0] own_mask;
  logic [MBA_ID_W-1:0] own_index;
  always_comb
  begin
    id_next = id_reg;
    id_valid_next = 1'b1;
    single_next = single_reg;
    if (!id_valid_reg)
    begin
      id_next = PROCESSOR_IDENTIFIER_I;
      single_next = (PROCESSOR_IDENTIFIER_I == MBA_ID_SINGLE);
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      id_reg <= MBA_ID_SINGLE;
      id_valid_reg <= 1'b0;
      single_reg <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      id_reg <= id_next;
      id_valid_reg <= id_valid_next;
      single_reg <= single_next;
    end
  end
  assign own_index = id_reg - MBA_INDEX_ONE;
  assign own_mask = single_reg ? NUM_PROC'(0) : (NUM_PROC'(MBA_ONE_HOT_BASE) << own_index);
  ////////////////////////////////////////////////////////////////////////////
  // three-flop input synchronisers, change taken when stages two and three agree
  logic [NUM_PROC-1:0] req_s1_reg, req_s2_reg, req_s3_reg, req_reg, req_next;
  logic [2:0] rot_s_reg;
  logic rot_reg, rot_next;
  logic [2:0] cpa_s_reg;
  logic cpa_reg, cpa_next;
  always_comb
  begin
    req_next = req_reg;
    rot_next = rot_reg;
    cpa_next = cpa_reg;
    for (int i = 0; i < NUM_PROC; i++)
    begin
      if (req_s2_reg[i] == req_s3_reg[i])
        req_next[i] = ~req_s2_reg[i];
    end
    if (rot_s_reg[1] == rot_s_reg[2])
      rot_next = rot_s_reg[1];
    if (cpa_s_reg[1] == cpa_s_reg[2])
      cpa_next = ~cpa_s_reg[1];
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      req_s1_reg <= '1;
      req_s2_reg <= '1;
      req_s3_reg <= '1;
      req_reg <= '0;
      rot_s_reg <= 3'h0;
      rot_reg <= 1'b0;
      cpa_s_reg <= 3'h7;
      cpa_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      req_s1_reg <= BUS.bus_request_lines_n[NUM_PROC-1:0];
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      req_reg <= req_next;
      rot_s_reg <= {rot_s_reg[1:0], BUS.rotating_priority_select};
      rot_reg <= rot_next;
      cpa_s_reg <= {cpa_s_reg[1:0], BUS.core_priority_line_n};
      cpa_reg <= cpa_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // arbitration: all devices compute the same winner from the same lines
  logic [MBA_ID_W-1:0] last_reg, last_next;
  logic hold_reg, hold_next;
  logic [MBA_ID_W-1:0] winner;
  logic winner_ok;
  logic [MBA_ID_W-1:0] cand;
  always_comb
  begin
    winner = MBA_INDEX_ZERO;
    winner_ok = 1'b0;
    cand = MBA_INDEX_ZERO;
    for (int k = NUM_PROC - 1; k >= 0; k--)
    begin
      if (rot_reg)
        cand = MBA_ID_W'((int'(last_reg) + 1 + k) % NUM_PROC);
      else
        cand = MBA_ID_W'(k);
      if (req_reg[cand])
      begin
        winner = cand;
        winner_ok = 1'b1;
      end
    end
    // the current holder keeps the bus while its request stands
    if (hold_reg && req_reg[last_reg])
    begin
      winner = last_reg;
      winner_ok = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // request state machine
  mba_state_t state_reg, state_next;
  logic drive_reg, drive_next;
  logic grant_reg, grant_next;
  logic yield_reg, yield_next;
  logic cpa_drive_reg, cpa_drive_next;
  always_comb
  begin
    state_next = state_reg;
    drive_next = drive_reg;
    grant_next = 1'b0;
    last_next = last_reg;
    yield_next = 1'b0;
    cpa_drive_next = 1'b0;
    hold_next = winner_ok;
    if (winner_ok)
      last_next = winner;
    unique case (state_reg)
      MBA_IDLE:
      begin
        drive_next = 1'b0;
        if (BUS_WANT_I && !single_reg && id_valid_reg)
        begin
          state_next = MBA_REQUEST;
          drive_next = 1'b1;
        end
      end
      MBA_REQUEST:
      begin
        cpa_drive_next = CORE_WANT_I && BUS_WANT_I;
        if (!BUS_WANT_I)
        begin
          state_next = MBA_IDLE;
          drive_next = 1'b0;
        end
        else if (winner_ok && (own_mask[winner]))
        begin
          state_next = MBA_MASTER;
          grant_next = 1'b1;
        end
      end
      MBA_MASTER:
      begin
        grant_next = 1'b1;
        yield_next = cpa_reg && DMA_BACKGROUND_I && !CORE_WANT_I;
        if (!BUS_WANT_I || yield_next)
        begin
          state_next = MBA_IDLE;
          drive_next = 1'b0;
          grant_next = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_reg <= MBA_IDLE;
      drive_reg <= 1'b0;
      grant_reg <= 1'b0;
      last_reg <= MBA_LAST_INDEX;
      hold_reg <= 1'b0;
      yield_reg <= 1'b0;
      cpa_drive_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      state_reg <= state_next;
      drive_reg <= drive_next;
      grant_reg <= grant_next;
      last_reg <= last_next;
      hold_reg <= hold_next;
      yield_reg <= yield_next;
      cpa_drive_reg <= cpa_drive_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  genvar g;
  generate
    for (g = 0; g < MBA_MAX_PROC; g++)
    begin : g_pin
      if (g < NUM_PROC)
      begin : g_used
        assign BUS.dev_req_drive[g] = drive_reg & own_mask[g];
        assign BUS.dev_req_oe_n[g] = ~own_mask[g];
      end
      else
      begin : g_unused
        assign BUS.dev_req_drive[g] = 1'b0;
        assign BUS.dev_req_oe_n[g] = 1'b1;
      end
    end
  endgenerate
  assign BUS.core_priority_line_oe_n_dev = ~cpa_drive_reg;
  assign BUS_GRANT_O = grant_reg;
  assign DMA_YIELD_O = yield_reg;
  assign SINGLE_PROC_O = single_reg;
endmodule

//--- hdl/mba_peer.sv
// peer end: the other processors' request lines, select level and core priority
module mba_peer
  import mba_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic CLK_EN_I,
  input wire logic [MBA_MAX_PROC-1:0] PEER_REQ_I,
  input wire logic [MBA_MAX_PROC-1:0] PEER_PRESENT_I,
  input wire logic ROT_SELECT_I,
  input wire logic CORE_PRIORITY_I,
  output logic [MBA_MAX_PROC-1:0] LINE_LEVEL_N_O,
  output logic CORE_PRIORITY_SEEN_O,
  mba_bus_if.peer BUS
);
  ////////////////////////////////////////////////////////////////////////////
  // registered drives
  logic [MBA_MAX_PROC-1:0] req_reg, req_next, oe_n_reg, oe_n_next;
  logic rot_reg, rot_next, cpa_reg, cpa_next;
  logic [MBA_MAX_PROC-1:0] lvl_reg;
  logic seen_reg;
  always_comb
  begin
    oe_n_next = ~PEER_PRESENT_I;
    req_next = PEER_REQ_I & PEER_PRESENT_I;
    rot_next = ROT_SELECT_I;
    cpa_next = CORE_PRIORITY_I;
  end
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      req_reg <= MBA_REQ_IDLE;
      oe_n_reg <= '1;
      rot_reg <= 1'b0;
      cpa_reg <= 1'b0;
      lvl_reg <= '1;
      seen_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      req_reg <= req_next;
      oe_n_reg <= oe_n_next;
      rot_reg <= rot_next;
      cpa_reg <= cpa_next;
      lvl_reg <= BUS.bus_request_lines_n;
      seen_reg <= ~BUS.core_priority_line_n;
    end
  end
  assign BUS.peer_req_drive = req_reg;
  assign BUS.peer_req_oe_n = oe_n_reg;
  assign BUS.rotating_priority_select = rot_reg;
  assign BUS.core_priority_line_oe_n_peer = ~cpa_reg;
  assign LINE_LEVEL_N_O = lvl_reg;
  assign CORE_PRIORITY_SEEN_O = seen_reg;
endmodule

//--- hdl/mba_pkg.sv
// package: constants and types shared by the bus request arbiter ends
package mba_pkg;
  localparam int MBA_MAX_PROC = 6;
  localparam int MBA_ID_W = 3;
  localparam logic [MBA_ID_W-1:0] MBA_ID_SINGLE = 3'h0;
  localparam logic [MBA_MAX_PROC-1:0] MBA_REQ_IDLE = 6'h00;
  localparam logic [MBA_MAX_PROC-1:0] MBA_ONE_HOT_BASE = 6'h01;
  localparam logic [MBA_ID_W-1:0] MBA_LAST_INDEX = 3'h5;
  localparam logic [MBA_ID_W-1:0] MBA_INDEX_ZERO = 3'h0;
  localparam logic [MBA_ID_W-1:0] MBA_INDEX_ONE = 3'h1;
  typedef enum logic [1:0] {MBA_IDLE, MBA_REQUEST, MBA_MASTER} mba_state_t;
endpackage

//--- verification/mba_asserts.sv
// checker: properties on the shared request and core priority lines
module mba_asserts
  import mba_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [MBA_ID_W-1:0] PROCESSOR_IDENTIFIER_I,
  input wire logic BUS_WANT_I,
  input wire logic BUS_GRANT_O,
  input wire logic [MBA_MAX_PROC-1:0] dev_req_drive,
  input wire logic [MBA_MAX_PROC-1:0] dev_req_oe_n,
  input wire logic core_priority_line_oe_n_dev,
  input wire logic core_priority_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MBA_MAX_PROC-1:0] own;
  logic [MBA_MAX_PROC-1:0] drv;
  assign own = (PROCESSOR_IDENTIFIER_I == MBA_ID_SINGLE) ? MBA_REQ_IDLE :
               MBA_ONE_HOT_BASE << (PROCESSOR_IDENTIFIER_I - 3'h1);
  assign drv = ~dev_req_oe_n;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////////////////////////////
  chk_own_line: assert property ((drv & ~own) == 6'h00)
    else $error("request line outside own slot driven");
  chk_single_quiet: assert property (PROCESSOR_IDENTIFIER_I == 3'h0 |-> drv == 6'h00)
    else $error("single processor id drives a request line");
  chk_drive_level: assert property ($past(RSTN_I) |-> (drv & own) == own)
    else $error("own request line not enabled as output");
  chk_req_answer: assert property ($rose(BUS_WANT_I) && own != 6'h00 |-> ##[1:3] (dev_req_drive & own) != 6'h00)
    else $error("own request line not driven after bus want");
  chk_grant_owns: assert property (BUS_GRANT_O |-> (dev_req_drive & own) != 6'h00)
    else $error("grant without own request line low");
  chk_grant_sync: assert property ($rose(BUS_GRANT_O) |-> $past(dev_req_drive & own, 3) != 6'h00)
    else $error("grant before own request was synchronised");
  chk_grant_drop: assert property ($fell(BUS_WANT_I) |-> ##[1:2] (!BUS_GRANT_O && dev_req_drive == 6'h00))
    else $error("grant or request line kept after want dropped");
  chk_core_od: assert property (!core_priority_line_oe_n_dev |-> !core_priority_line_n && (dev_req_drive & own) != 6'h00)
    else $error("core priority pulled outside a request");
endmodule

//--- verification/multiprocessor_bus_request_arbiter_test.sv
// testbench: device and peer ends joined, checked against a priority model
module multiprocessor_bus_request_arbiter_test;
  import mba_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, clk_en, bus_want, core_want, dma_bg, rot, core_pri;
  logic grant, yield_o, single, cp_seen;
  logic [2:0] id;
  logic [5:0] peer_req, present, lines_n;
  int err_count, checked, cycles, last, n;
  mba_bus_if bus_if();
  mba_device u_mba_device (.REF_CLK_I(clk), .RSTN_I(rst_n), .CLK_EN_I(clk_en), .PROCESSOR_IDENTIFIER_I(id),
    .BUS_WANT_I(bus_want), .CORE_WANT_I(core_want), .DMA_BACKGROUND_I(dma_bg), .BUS_GRANT_O(grant),
    .DMA_YIELD_O(yield_o), .SINGLE_PROC_O(single), .BUS(bus_if.device));
  mba_peer u_mba_peer (.REF_CLK_I(clk), .RSTN_I(rst_n), .CLK_EN_I(clk_en), .PEER_REQ_I(peer_req),
    .PEER_PRESENT_I(present), .ROT_SELECT_I(rot), .CORE_PRIORITY_I(core_pri), .LINE_LEVEL_N_O(lines_n),
    .CORE_PRIORITY_SEEN_O(cp_seen), .BUS(bus_if.peer));
  mba_asserts u_mba_asserts (.REF_CLK_I(clk), .RSTN_I(rst_n), .PROCESSOR_IDENTIFIER_I(id), .BUS_WANT_I(bus_want),
    .BUS_GRANT_O(grant), .dev_req_drive(bus_if.dev_req_drive), .dev_req_oe_n(bus_if.dev_req_oe_n),
    .core_priority_line_oe_n_dev(bus_if.core_priority_line_oe_n_dev),
    .core_priority_line_n(bus_if.core_priority_line_n));
  ////////////////////////////////////////////////////////////////
  function automatic logic [5:0] own_of(input logic [2:0] i);
    own_of = (i == 3'h0) ? 6'h00 : 6'h01 << (i - 3'h1);
  endfunction
  // highest priority requester; rotating starts after the last master
  function automatic int winner(input logic [5:0] m, input logic r);
    int x;
    winner = 0;
    for (int k = 6; k >= 1; k--)
    begin
      x = r ? (last + k - 1) % 6 + 1 : k;
      if (m[x-1] === 1'b1) winner = x;
    end
  endfunction
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task reset_to(input logic [2:0] i, input logic r);
    rst_n <= 1'b0;
    id <= i;
    rot <= r;
    bus_want <= 1'b0;
    peer_req <= 6'h00;
    present <= ~own_of(i);
    last = 6;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // one contest against peers p, then peers release and device must win unless its id is 0
  task arb(input logic [5:0] p);
    logic e;
    e = (id != 3'h0) && (winner(p | own_of(id), rot) == int'(id));
    peer_req <= p;
    bus_want <= 1'b1;
    repeat (12) @(negedge clk);
    chk("lines", {2'h0, ~(p | own_of(id))}, {2'h0, lines_n});
    chk("grant", {7'h0, e}, {7'h0, grant});
    @(posedge clk);
    peer_req <= 6'h00;
    for (n = 0; n < 20 && grant !== (id != 3'h0); n++) @(negedge clk);
    chk("grant after release", {7'h0, id != 3'h0}, {7'h0, grant});
    if (grant === 1'b1) last = int'(id);
    @(posedge clk);
    bus_want <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    clk_en = 1'b1;
    core_want = 1'b0;
    dma_bg = 1'b0;
    core_pri = 1'b0;
    void'($urandom(32'hc4ca));
    for (int i = 0; i <= 6; i++)
    begin
      reset_to(3'(i), 1'b0);
      @(negedge clk);
      chk("single", {7'h0, i == 0}, {7'h0, single});
      @(posedge clk);
      arb((6'h01 << $urandom_range(5, 0)) & ~own_of(3'(i)));
    end
    $display("test fixed priority done");
    reset_to(3'h3, 1'b1);
    arb(6'h00);
    arb(6'h10);
    arb(6'h01);
    rot <= 1'b0;
    @(posedge clk);
    arb(6'h10);
    $display("test rotating priority done");
    reset_to(3'h2, 1'b0);
    peer_req <= 6'h01;
    bus_want <= 1'b1;
    core_want <= 1'b1;
    repeat (10) @(negedge clk);
    chk("core seen", 8'h01, {7'h0, cp_seen});
    chk("held off", 8'h00, {7'h0, grant});
    @(posedge clk);
    core_want <= 1'b0;
    peer_req <= 6'h00;
    dma_bg <= 1'b1;
    repeat (12) @(negedge clk);
    chk("master", 8'h01, {7'h0, grant});
    @(posedge clk);
    core_pri <= 1'b1;
    for (n = 0; n < 10 && yield_o !== 1'b1; n++) @(negedge clk);
    chk("yield", 8'h01, {7'h0, yield_o});
    @(negedge clk);
    chk("yield pulse", 8'h00, {7'h0, yield_o});
    @(posedge clk);
    core_pri <= 1'b0;
    bus_want <= 1'b0;
    dma_bg <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test core priority done");
    print_verdict();
  end
endmodule
